// ---- hdl/rsec_pkg.sv ----
// Shared constants for the receive signaling and error counter bank
package rsec_pkg;
    localparam int         ADDR_W          = 8;
    localparam int         DATA_W          = 8;
    localparam int         CNT_W           = 16;
    localparam int         SIG_REGS        = 16;
    localparam logic [7:0] SIG_BASE_ADDR   = 8'h40;
    localparam logic [7:0] SIG_LAST_ADDR   = 8'h4F;
    localparam logic [7:0] LINE_HI_ADDR    = 8'h50;
    localparam logic [7:0] LINE_LO_ADDR    = 8'h51;
    localparam logic [7:0] PATH_HI_ADDR    = 8'h52;
    localparam logic [7:0] PATH_LO_ADDR    = 8'h53;
    localparam logic [7:0] UNSYNC_HI_ADDR  = 8'h54;
    localparam logic [7:0] UNSYNC_LO_ADDR  = 8'h55;
    localparam logic [7:0] EBIT_HI_ADDR    = 8'h56;
    localparam logic [7:0] EBIT_LO_ADDR    = 8'h57;
    localparam logic [7:0] MON_DATA_ADDR   = 8'h60;
    localparam logic [7:0] FW_REV_ADDR     = 8'h61;
    localparam logic [7:0] BYTE_RESET      = 8'h00;
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [3:0] NIBBLE_ZERO     = 4'h0;
    // E1: second channel of a register is n + 15
    localparam int         E1_PAIR_OFFSET  = 15;
    // T1: second channel of a register is n + 12
    localparam int         T1_PAIR_OFFSET  = 12;
    localparam int         CH_IDX_W        = 5;
endpackage

// ---- hdl/rsec_counter.sv ----
`timescale 1ns/1ns
// Saturation-free 16-bit event counter used for each error count
module rsec_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             enable,
    input  wire logic             event_in,
    output logic [WIDTH-1:0]      count
);
    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } rsec_cnt_state_t;

    rsec_cnt_state_t state_ff;
    rsec_cnt_state_t nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (enable && event_in) begin
            nxt_state.cnt = state_ff.cnt + WIDTH'(1); // see R16
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign count = state_ff.cnt;

    countStep_a: assert property (@(posedge clk) disable iff (!rst_n) // see R16
        (enable && event_in) |=> (count == $past(count) + WIDTH'(1)))
        else $error("counter did not step by one on an event");
    countHold_a: assert property (@(posedge clk) disable iff (!rst_n) // see R16
        !(enable && event_in) |=> $stable(count))
        else $error("counter moved without an event");
endmodule

// ---- hdl/rsec_bank.sv ----
`timescale 1ns/1ns
// Receive signaling registers, error counters, DS0 monitor and firmware revision

// Overview of operation
// R1 - ESF: capture A, B, C, D signaling bits per channel.
// R2 - D4: only A and B signaling bits are extracted per channel.
// R3 - D4: received A and B are repeated into the C and D positions.
// R4 - Host reads signaling every 1.5 ms in D4, every 3 ms in ESF.
// R5 - Signaling registers freeze during loss of sync, keeping last values.
// R6 - E1: register n+1 holds channel n upper nibble, channel n+15 lower nibble.
// R7 - 16-bit line violation count, high byte 050h, low byte 051h.
// R8 - 16-bit path violation count, high byte 052h, low byte 053h.
// R9 - 16-bit unsynced frames count, low byte at 055h.
// R10 - E1 only: 16-bit E-bit count, high byte at 056h.
// R11 - Monitor register 060h shows latest byte of the selected DS0 channel.
// R12 - Monitor: first received bit at bit 7, last at bit 0.
// R13 - E1 only: 8-bit firmware revision readable at 061h.
// R14 - Sixteen signaling registers at offsets 040h to 04Fh.
// R15 - Firmware revision is read-only; writes leave it unchanged.
// R16 - Each counter increments by one per event of its own kind.
module rsec_bank #(
    parameter logic [7:0] FW_REVISION = 8'h5A  // Arbitrary value
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                e1Mode,
    input  wire logic                esfMode,
    input  wire logic                outOfFrameCondition,
    input  wire logic                sigValid,
    input  wire logic [4:0]          sigChannel,
    input  wire logic [3:0]          sigAbcd,
    input  wire logic                lineViolation,
    input  wire logic                pathViolation,
    input  wire logic                unsyncedFrame,
    input  wire logic                ebitEvent,
    input  wire logic [4:0]          channelMonitorSelect,
    input  wire logic                rxBitValid,
    input  wire logic                rxBit,
    input  wire logic [4:0]          rxChannel,
    input  wire logic                rxChannelLast,
    input  wire logic                regRead,
    input  wire logic                regWrite,
    input  wire logic [7:0]          regAddr,
    input  wire logic [7:0]          regWdata,
    output logic [7:0]               regRdata
);
    typedef struct packed {
        logic [rsec_pkg::SIG_REGS-1:0][7:0] sig;
        logic [7:0]                         monShift;
        logic [7:0]                         monData;
        logic [7:0]                         rdata;
    } rsec_state_t;

    rsec_state_t  state_ff;
    rsec_state_t  nxt_state;
    logic [15:0]  lineCount;
    logic [15:0]  pathCount;
    logic [15:0]  unsyncCount;
    logic [15:0]  ebitCount;
    logic [7:0]   readMux;

    rsec_counter #(.WIDTH(rsec_pkg::CNT_W)) uLine (
        .clk      (clk),
        .rst_n    (rst_n),
        .enable   (1'b1),
        .event_in (lineViolation), // see R7
        .count    (lineCount)
    );
    rsec_counter #(.WIDTH(rsec_pkg::CNT_W)) uPath (
        .clk      (clk),
        .rst_n    (rst_n),
        .enable   (1'b1),
        .event_in (pathViolation), // see R8
        .count    (pathCount)
    );
    rsec_counter #(.WIDTH(rsec_pkg::CNT_W)) uUnsync (
        .clk      (clk),
        .rst_n    (rst_n),
        .enable   (1'b1),
        .event_in (unsyncedFrame), // see R9
        .count    (unsyncCount)
    );
    // E-bits only exist in E1 framing
    rsec_counter #(.WIDTH(rsec_pkg::CNT_W)) uEbit (
        .clk      (clk),
        .rst_n    (rst_n),
        .enable   (e1Mode), // see R10
        .event_in (ebitEvent),
        .count    (ebitCount)
    );

    // Channel to register slot and nibble
    function automatic logic [5:0] sigSlot(input logic e1, input logic [4:0] ch);
        logic [5:0] slot;
        slot = 6'h3F;
        if (e1) begin
            if (ch >= 5'd1 && ch <= 5'd15) begin
                slot = {1'b1, ch}; // see R6
            end else if (ch >= 5'd16 && ch <= 5'd30) begin
                slot = {1'b0, 5'(ch - 5'(rsec_pkg::E1_PAIR_OFFSET))}; // see R6
            end
        end else begin
            if (ch >= 5'd1 && ch <= 5'd12) begin
                slot = {1'b1, 5'(ch - 5'd1)};
            end else if (ch >= 5'd13 && ch <= 5'd24) begin
                slot = {1'b0, 5'(ch - 5'(rsec_pkg::T1_PAIR_OFFSET) - 5'd1)};
            end
        end
        return slot;
    endfunction

    always_comb begin
        logic [5:0] slot;
        logic [3:0] abcd;
        slot = sigSlot(e1Mode, sigChannel);
        abcd = sigAbcd;
        nxt_state = state_ff;
        // D4 carries only A and B; repeat them as C and D
        if (!e1Mode && !esfMode) begin
            abcd = {sigAbcd[3:2], sigAbcd[3:2]}; // see R2, R3
        end
        // Frozen during loss of sync so software sees pre-OUT_OF_FRAME_CONDITION state
        if (sigValid && !outOfFrameCondition && slot != 6'h3F) begin // see R5
            if (slot[5]) begin
                nxt_state.sig[slot[3:0]][7:4] = abcd; // see R1
            end else begin
                nxt_state.sig[slot[3:0]][3:0] = abcd; // see R1
            end
        end
        // Register 1 in E1 carries no channel signaling in its upper nibble
        if (e1Mode) begin
            nxt_state.sig[0][7:4] = rsec_pkg::NIBBLE_ZERO; // see R6
        end
        if (rxBitValid && rxChannel == channelMonitorSelect) begin
            nxt_state.monShift = {state_ff.monShift[6:0], rxBit}; // see R12
            if (rxChannelLast) begin
                nxt_state.monData = {state_ff.monShift[6:0], rxBit}; // see R11
            end
        end
        nxt_state.rdata = regRead ? readMux : state_ff.rdata;
    end

    // Address decode; all registers here are read-only so writes are ignored
    always_comb begin
        readMux = rsec_pkg::BYTE_RESET;
        if (regAddr >= rsec_pkg::SIG_BASE_ADDR && regAddr <= rsec_pkg::SIG_LAST_ADDR) begin
            readMux = state_ff.sig[regAddr[3:0]]; // see R14
        end else if (regAddr == rsec_pkg::LINE_HI_ADDR) begin
            readMux = lineCount[15:8]; // see R7
        end else if (regAddr == rsec_pkg::LINE_LO_ADDR) begin
            readMux = lineCount[7:0]; // see R7
        end else if (regAddr == rsec_pkg::PATH_HI_ADDR) begin
            readMux = pathCount[15:8]; // see R8
        end else if (regAddr == rsec_pkg::PATH_LO_ADDR) begin
            readMux = pathCount[7:0]; // see R8
        end else if (regAddr == rsec_pkg::UNSYNC_HI_ADDR) begin
            readMux = unsyncCount[15:8];
        end else if (regAddr == rsec_pkg::UNSYNC_LO_ADDR) begin
            readMux = unsyncCount[7:0]; // see R9
        end else if (regAddr == rsec_pkg::EBIT_HI_ADDR && e1Mode) begin
            readMux = ebitCount[15:8]; // see R10
        end else if (regAddr == rsec_pkg::EBIT_LO_ADDR && e1Mode) begin
            readMux = ebitCount[7:0];
        end else if (regAddr == rsec_pkg::MON_DATA_ADDR) begin
            readMux = state_ff.monData; // see R11
        end else if (regAddr == rsec_pkg::FW_REV_ADDR && e1Mode) begin
            readMux = FW_REVISION; // see R13, R15
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign regRdata = state_ff.rdata;

    sigFreeze_a: assert property (@(posedge clk) disable iff (!rst_n) // see R5
        outOfFrameCondition |=> (state_ff.sig[15:1] == $past(state_ff.sig[15:1])))
        else $error("signaling changed during loss of sync");
    d4Repeat_a: assert property (@(posedge clk) disable iff (!rst_n) // see R3
        (sigValid && !outOfFrameCondition && !e1Mode && !esfMode && sigChannel == 5'd1)
        |=> (state_ff.sig[0][7:6] == state_ff.sig[0][5:4]))
        else $error("D4 C and D do not repeat A and B");
    esfCapture_a: assert property (@(posedge clk) disable iff (!rst_n) // see R1
        (sigValid && !outOfFrameCondition && !e1Mode && esfMode && sigChannel == 5'd13)
        |=> (state_ff.sig[0][3:0] == $past(sigAbcd)))
        else $error("ESF signaling not captured");
    e1Map_a: assert property (@(posedge clk) disable iff (!rst_n) // see R6
        (sigValid && !outOfFrameCondition && e1Mode && sigChannel == 5'd16)
        |=> (state_ff.sig[1][3:0] == $past(sigAbcd)))
        else $error("E1 channel 16 not in lower nibble of register 2");
    lineRead_a: assert property (@(posedge clk) disable iff (!rst_n) // see R7
        (regRead && regAddr == rsec_pkg::LINE_LO_ADDR) |=> (regRdata == $past(lineCount[7:0])))
        else $error("line count low byte misread");
    pathRead_a: assert property (@(posedge clk) disable iff (!rst_n) // see R8
        (regRead && regAddr == rsec_pkg::PATH_HI_ADDR) |=> (regRdata == $past(pathCount[15:8])))
        else $error("path count high byte misread");
    unsyncRead_a: assert property (@(posedge clk) disable iff (!rst_n) // see R9
        (regRead && regAddr == rsec_pkg::UNSYNC_LO_ADDR) |=> (regRdata == $past(unsyncCount[7:0])))
        else $error("unsynced count low byte misread");
    ebitHold_a: assert property (@(posedge clk) disable iff (!rst_n) // see R10
        !e1Mode |=> $stable(ebitCount))
        else $error("E-bit count moved outside E1");
    fwRead_a: assert property (@(posedge clk) disable iff (!rst_n) // see R13
        (regRead && e1Mode && regAddr == rsec_pkg::FW_REV_ADDR)
        |=> (regRdata == FW_REVISION))
        else $error("firmware revision misread");
    monOrder_a: assert property (@(posedge clk) disable iff (!rst_n) // see R12
        (rxBitValid && rxChannel == channelMonitorSelect && rxChannelLast)
        |=> (state_ff.monData[0] == $past(rxBit)))
        else $error("last DS0 bit not at bit 0");

    // Read path: every mapped byte returns its source one cycle later
    lineHiRead_a: assert property (@(posedge clk) disable iff (!rst_n) // see R7
        (regRead && regAddr == rsec_pkg::LINE_HI_ADDR) |=> (regRdata == $past(lineCount[15:8])))
        else $error("line count high byte misread");

    pathLoRead_a: assert property (@(posedge clk) disable iff (!rst_n) // see R8
        (regRead && regAddr == rsec_pkg::PATH_LO_ADDR) |=> (regRdata == $past(pathCount[7:0])))
        else $error("path count low byte misread");

    unsyncHiRead_a: assert property (@(posedge clk) disable iff (!rst_n) // see R9
        (regRead && regAddr == rsec_pkg::UNSYNC_HI_ADDR) |=> (regRdata == $past(unsyncCount[15:8])))
        else $error("unsynced count high byte misread");

    ebitHiRead_a: assert property (@(posedge clk) disable iff (!rst_n) // see R10
        (regRead && e1Mode && regAddr == rsec_pkg::EBIT_HI_ADDR) |=> (regRdata == $past(ebitCount[15:8])))
        else $error("E-bit count high byte misread");

    ebitLoRead_a: assert property (@(posedge clk) disable iff (!rst_n) // see R10
        (regRead && e1Mode && regAddr == rsec_pkg::EBIT_LO_ADDR) |=> (regRdata == $past(ebitCount[7:0])))
        else $error("E-bit count low byte misread");

    // E1-only registers read as zero in T1
    ebitT1Read_a: assert property (@(posedge clk) disable iff (!rst_n) // see R10
        (regRead && !e1Mode && (regAddr == rsec_pkg::EBIT_HI_ADDR || regAddr == rsec_pkg::EBIT_LO_ADDR))
        |=> (regRdata == rsec_pkg::BYTE_RESET))
        else $error("E-bit count visible in T1");

    fwT1Read_a: assert property (@(posedge clk) disable iff (!rst_n) // see R13
        (regRead && !e1Mode && regAddr == rsec_pkg::FW_REV_ADDR) |=> (regRdata == rsec_pkg::BYTE_RESET))
        else $error("firmware revision visible in T1");

    fwWrite_a: assert property (@(posedge clk) disable iff (!rst_n) // see R15
        (regWrite && e1Mode && regAddr == rsec_pkg::FW_REV_ADDR) ##[1:4]
        (regRead && e1Mode && regAddr == rsec_pkg::FW_REV_ADDR) |=> (regRdata == FW_REVISION))
        else $error("firmware revision altered by a write");

    monRead_a: assert property (@(posedge clk) disable iff (!rst_n) // see R11
        (regRead && regAddr == rsec_pkg::MON_DATA_ADDR) |=> (regRdata == $past(state_ff.monData)))
        else $error("monitor register misread");

    sigRead_a: assert property (@(posedge clk) disable iff (!rst_n) // see R14
        (regRead && regAddr >= rsec_pkg::SIG_BASE_ADDR && regAddr <= rsec_pkg::SIG_LAST_ADDR)
        |=> (regRdata == $past(state_ff.sig[regAddr[3:0]])))
        else $error("signaling register misread");

    unmappedRead_a: assert property (@(posedge clk) disable iff (!rst_n)
        (regRead && (regAddr < rsec_pkg::SIG_BASE_ADDR || (regAddr > rsec_pkg::EBIT_LO_ADDR
        && regAddr != rsec_pkg::MON_DATA_ADDR && regAddr != rsec_pkg::FW_REV_ADDR)))
        |=> (regRdata == rsec_pkg::BYTE_RESET))
        else $error("unmapped address returned data");

    // Read data stands until the next read
    rdataHold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !regRead |=> $stable(regRdata))
        else $error("read data changed without a read");

    // Monitor shift and capture
    monFirst_a: assert property (@(posedge clk) disable iff (!rst_n) // see R12
        (rxBitValid && rxChannel == channelMonitorSelect && rxChannelLast)
        |=> (state_ff.monData[7] == $past(state_ff.monShift[6])))
        else $error("first DS0 bit not at bit 7");

    monShift_a: assert property (@(posedge clk) disable iff (!rst_n) // see R12
        (rxBitValid && rxChannel == channelMonitorSelect) |=> (state_ff.monShift[0] == $past(rxBit)))
        else $error("DS0 bit not shifted in");

    monHold_a: assert property (@(posedge clk) disable iff (!rst_n) // see R11
        !(rxBitValid && rxChannel == channelMonitorSelect && rxChannelLast) |=> $stable(state_ff.monData))
        else $error("monitor changed without a full byte");

    // Signaling placement per framing mode
    e1Slot0_a: assert property (@(posedge clk) disable iff (!rst_n) // see R6
        e1Mode |=> (state_ff.sig[0][7:4] == rsec_pkg::NIBBLE_ZERO))
        else $error("first E1 register upper nibble not zero");

    e1Ch1_a: assert property (@(posedge clk) disable iff (!rst_n) // see R6
        (sigValid && !outOfFrameCondition && e1Mode && sigChannel == 5'd1)
        |=> (state_ff.sig[1][7:4] == $past(sigAbcd)))
        else $error("E1 channel 1 not in upper nibble of register 2");

    e1Ch15_a: assert property (@(posedge clk) disable iff (!rst_n) // see R6
        (sigValid && !outOfFrameCondition && e1Mode && sigChannel == 5'd15)
        |=> (state_ff.sig[15][7:4] == $past(sigAbcd)))
        else $error("E1 channel 15 misplaced");

    e1Ch30_a: assert property (@(posedge clk) disable iff (!rst_n) // see R6
        (sigValid && !outOfFrameCondition && e1Mode && sigChannel == 5'd30)
        |=> (state_ff.sig[15][3:0] == $past(sigAbcd)))
        else $error("E1 channel 30 misplaced");

    esfUpper_a: assert property (@(posedge clk) disable iff (!rst_n) // see R1
        (sigValid && !outOfFrameCondition && !e1Mode && esfMode && sigChannel == 5'd12)
        |=> (state_ff.sig[11][7:4] == $past(sigAbcd)))
        else $error("ESF channel 12 not captured");

    d4AbOnly_a: assert property (@(posedge clk) disable iff (!rst_n) // see R2
        (sigValid && !outOfFrameCondition && !e1Mode && !esfMode && sigChannel == 5'd1)
        |=> (state_ff.sig[0][7:6] == $past(sigAbcd[3:2])))
        else $error("D4 A and B not captured");

    d4Lower_a: assert property (@(posedge clk) disable iff (!rst_n) // see R3
        (sigValid && !outOfFrameCondition && !e1Mode && !esfMode && sigChannel == 5'd24)
        |=> (state_ff.sig[11][3:2] == state_ff.sig[11][1:0]))
        else $error("D4 lower nibble does not repeat A and B");

    // In T1 nothing but a valid in-frame strobe moves the signaling bank
    t1Freeze_a: assert property (@(posedge clk) disable iff (!rst_n) // see R5
        (outOfFrameCondition && !e1Mode) |=> $stable(state_ff.sig))
        else $error("T1 signaling changed during loss of sync");

    sigIdle_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!sigValid && !e1Mode) |=> $stable(state_ff.sig))
        else $error("signaling changed without a strobe");

    // Counters seen from the bank
    lineHold_a: assert property (@(posedge clk) disable iff (!rst_n) // see R16
        !lineViolation |=> $stable(lineCount))
        else $error("line count moved without an event");

    pathHold_a: assert property (@(posedge clk) disable iff (!rst_n) // see R16
        !pathViolation |=> $stable(pathCount))
        else $error("path count moved without an event");

    unsyncHold_a: assert property (@(posedge clk) disable iff (!rst_n) // see R16
        !unsyncedFrame |=> $stable(unsyncCount))
        else $error("unsynced count moved without an event");

    ebitStep_a: assert property (@(posedge clk) disable iff (!rst_n) // see R10
        (e1Mode && ebitEvent) |=> (ebitCount == $past(ebitCount) + 16'h0001))
        else $error("E-bit count did not step in E1");
endmodule

// ---- testbench/rsec_bank_tb.sv ----
`timescale 1ns/1ns
// Self-checking bench for the receive signaling and error counter bank
module rsec_bank_tb;
    logic        clk;
    logic        rst_n;
    logic        e1Mode;
    logic        esfMode;
    logic        outOfFrameCondition;
    logic        sigValid;
    logic [4:0]  sigChannel;
    logic [3:0]  sigAbcd;
    logic [3:0]  evt;
    logic [4:0]  channelMonitorSelect;
    logic        rxBitValid;
    logic        rxBit;
    logic [4:0]  rxChannel;
    logic        rxChannelLast;
    logic        regRead;
    logic        regWrite;
    logic [7:0]  regAddr;
    logic [7:0]  regWdata;
    logic [7:0]  regRdata;
    logic [7:0]  sigModel [16];
    logic [7:0]  monByte;
    integer      seed = 53;
    int          fails = 0;
    int          checks = 0;
    int          cycles = 0;
    int          n;

    // Identifier value is arbitrary
    rsec_bank #(.FW_REVISION(8'hA5)) rsec_bank_i (
        .clk(clk), .rst_n(rst_n), .e1Mode(e1Mode), .esfMode(esfMode),
        .outOfFrameCondition(outOfFrameCondition), .sigValid(sigValid), .sigChannel(sigChannel),
        .sigAbcd(sigAbcd), .lineViolation(evt[0]), .pathViolation(evt[1]), .unsyncedFrame(evt[2]),
        .ebitEvent(evt[3]), .channelMonitorSelect(channelMonitorSelect), .rxBitValid(rxBitValid),
        .rxBit(rxBit), .rxChannel(rxChannel), .rxChannelLast(rxChannelLast), .regRead(regRead),
        .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Generous ceiling; the full sequence needs well under half of it
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        regRead = 1'b1;
        regAddr = a;
        @(negedge clk);
        regRead = 1'b0;
        check(regRdata, exp);
    endtask

    task automatic doReset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 16; i++) sigModel[i] = 8'h00;
    endtask

    task automatic pulse(input int k, input int times);
        repeat (times) begin
            @(negedge clk);
            evt[k] = 1'b1;
            @(negedge clk);
            evt[k] = 1'b0;
        end
    endtask

    task automatic sigRun(input int maxCh);
        logic [4:0] ch;
        logic [3:0] v;
        logic       frozen;
        int         idx;
        for (int i = 0; i < 24; i++) begin
            ch = (i == 0) ? 5'd1 : (i == 1) ? 5'(maxCh) : (i < 4) ? 5'(maxCh / 2 + i - 2)
                : 5'(1 + $unsigned($random(seed)) % maxCh);
            sigAbcd = 4'($random(seed));
            frozen = (i % 6 == 5);
            @(negedge clk);
            sigValid = 1'b1;
            sigChannel = ch;
            outOfFrameCondition = frozen;
            @(negedge clk);
            sigValid = 1'b0;
            outOfFrameCondition = 1'b0;
            // D4 keeps A and B only and repeats them as C and D
            v = (e1Mode || esfMode) ? sigAbcd : {sigAbcd[3:2], sigAbcd[3:2]};
            if (e1Mode) idx = (ch <= 15) ? ch : ch - 15;
            else idx = (ch <= 12) ? ch - 1 : ch - 13;
            if (!frozen) begin
                if ((e1Mode && ch <= 15) || (!e1Mode && ch <= 12)) sigModel[idx][7:4] = v;
                else sigModel[idx][3:0] = v;
            end
            rdchk(8'h40 + 8'(idx), sigModel[idx]);
        end
    endtask

    task automatic sendByte(input logic [4:0] ch, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk);
            rxBitValid = 1'b1;
            rxChannel = ch;
            rxBit = b[i];
            rxChannelLast = (i == 0);
        end
        @(negedge clk);
        rxBitValid = 1'b0;
        rxChannelLast = 1'b0;
    endtask

    initial begin
        {e1Mode, esfMode, outOfFrameCondition, sigValid, rxBitValid, rxBit} = 6'h20;
        {sigChannel, sigAbcd, evt, rxChannel, rxChannelLast, regRead, regWrite} = '0;
        channelMonitorSelect = 5'h03;
        regAddr = 8'h00;
        regWdata = 8'h00;
        rst_n = 1'b0;
        doReset();
        for (int a = 8'h40; a <= 8'h57; a++) rdchk(8'(a), 8'h00);
        rdchk(8'h60, 8'h00);
        sigRun(30);
        doReset();
        e1Mode = 1'b0;
        esfMode = 1'b1;
        sigRun(24);
        esfMode = 1'b0;
        sigRun(24);
        for (int k = 0; k < 4; k++) begin
            n = 250 + $unsigned($random(seed)) % 300;
            pulse(k, n);
            if (k < 3) begin
                rdchk(8'h50 + 8'(2 * k), 8'(n >> 8));
                rdchk(8'h51 + 8'(2 * k), 8'(n));
            end
        end
        rdchk(8'h56, 8'h00);
        rdchk(8'h61, 8'h00);
        e1Mode = 1'b1;
        rdchk(8'h56, 8'h00);
        rdchk(8'h61, 8'hA5);
        @(negedge clk);
        regWrite = 1'b1;
        regAddr = 8'h61;
        regWdata = 8'($random(seed));
        @(negedge clk);
        regWrite = 1'b0;
        rdchk(8'h61, 8'hA5);
        n = 256 + $unsigned($random(seed)) % 200;
        pulse(3, n);
        rdchk(8'h56, 8'(n >> 8));
        rdchk(8'h57, 8'(n));
        // Other channel bytes between selected ones must not leak in
        channelMonitorSelect = 5'(1 + $unsigned($random(seed)) % 23);
        for (int i = 0; i < 4; i++) begin
            monByte = 8'($random(seed));
            sendByte(channelMonitorSelect, monByte);
            sendByte(channelMonitorSelect + 5'd1, 8'($random(seed)));
            rdchk(8'h60, monByte);
        end
        rdchk(8'h3F, 8'h00);
        rdchk(8'h58, 8'h00);
        rdchk(8'hFF, 8'h00);
        conclude();
    end
endmodule
